// ===== core/pport_map.svh
// Purpose: register offsets, field positions and reset values of the sample output port
// Assumes: included by the package and by the port core
// Notes:   byte addresses on a 32-bit bus, one register per aligned word
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH

`define PP_CHANNELS        6
`define PP_CTRL_OFS        12'h000
`define PP_STATUS_OFS      12'h004

`define PP_CTRL_EN_LSB     0
`define PP_CTRL_PACKED_BIT 8
`define PP_CTRL_GAIN_BIT   9
`define PP_CTRL_MASTER_BIT 12
`define PP_CTRL_DIV_LSB    16
`define PP_CTRL_RESET      11'h000

`define PP_ST_PEND_LSB     0
`define PP_ST_REQ_BIT      8
`define PP_ST_STALL_BIT    9
`define PP_ST_TAG_LSB      12

`define PP_DIV_LAST_1      3'h0
`define PP_DIV_LAST_2      3'h1
`define PP_DIV_LAST_4      3'h3
`define PP_DIV_LAST_8      3'h7

`endif

// ===== core/pport_pkg.sv
// Purpose: types shared by the sample output port
// Assumes: map header holds every number
// Notes:   one-hot word states
`include "pport_map.svh"
package pport_pkg;

	typedef struct packed {
		logic [15:0] i_word;
		logic [15:0] q_word;
		logic [15:0] gain_word;
	} sample_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_FIRST  = 4'b0010,
		ST_SECOND = 4'b0100,
		ST_GAIN   = 4'b1000
	} word_state_t;

	typedef struct packed {
		logic [`PP_CHANNELS-1:0] enable;
		logic                    packed_fmt;
		logic                    append_gain;
		logic                    clk_master;
		logic [1:0]              div_code;
	} ctrl_t;

	typedef struct packed {
		logic [15:0] word;
		logic        request;
		logic        i_flag;
		logic        gain_flag;
		logic [2:0]  tag;
	} port_out_t;

	typedef struct packed {
		word_state_t                      st;
		ctrl_t                            ctrl;
		port_out_t                        pout;
		sample_t                          cur;
		logic [`PP_CHANNELS-1:0]          pending;
		sample_t [`PP_CHANNELS-1:0]       hold;
		logic [31:0]                      prdata;
	} core_state_t;

endpackage

// ===== core/bit_sync.sv
// Purpose: two-flop synchroniser for levels from outside the pclk domain
// Assumes: inputs are levels, each bit crosses on its own
// Notes:   only the second stage leaves this module
`timescale 1ns/1ns
module bit_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	always_comb begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;
endmodule

// ===== core/port_clock_gen.sv
// Purpose: port clock edge enable, master divider or slave edge detect
// Assumes: slave clock already synchronised, slower than pclk/4
// Notes:   a flop cannot copy pclk, so divisor one holds the pin high
`timescale 1ns/1ns
`include "pport_map.svh"
module port_clock_gen (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// settings
	input  wire logic       clk_master,
	input  wire logic [1:0] div_code,
	// port clock
	input  wire logic       port_clk_sync,
	output logic            port_edge,
	output logic            port_clk_out,
	output logic            port_clk_oe
);
	typedef struct packed {
		logic [2:0] count;
		logic       level;
		logic       oe;
		logic       prev;
	} gen_state_t;

	gen_state_t s;
	gen_state_t next_s;
	logic [2:0] last;

	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			2'h0:    div_last = `PP_DIV_LAST_1;
			2'h1:    div_last = `PP_DIV_LAST_2;
			2'h2:    div_last = `PP_DIV_LAST_4;
			default: div_last = `PP_DIV_LAST_8;
		endcase
	endfunction

	always_comb begin
		next_s      = s;
		last        = div_last(div_code);
		next_s.prev = port_clk_sync;
		next_s.oe   = clk_master;                                              // [R1] [R4]
		next_s.count = (s.count >= last) ? 3'h0 : s.count + 3'h1;              // [R2]
		next_s.level = (next_s.count <= (last >> 1));
		if (clk_master) begin
			port_edge = (s.count >= last);                                     // [R2]
		end else begin
			port_edge = port_clk_sync & ~s.prev;                               // [R3]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign port_clk_out = s.level;
	assign port_clk_oe  = s.oe;
endmodule

// ===== core/pport_core.sv
// Purpose: sample output port with request/accept handshake and APB registers
// Assumes: pclk 20 MHz; sources pulse sample_ready with data valid that cycle
// Notes:   one port; the port clock is an edge enable, never a second clock
//
// Functional notes
// [R1] port clock pin is driven when the master bit is set, input otherwise
// [R2] master mode divides the core clock by one, two, four or eight
// [R3] slave mode works with a port clock synchronous or asynchronous to core
// [R4] after reset the port clock pin is an input
// [R5] data, request, flags and tag change only on port clock rising edges
// [R6] request rises when data is available and holds until all is sent
// [R7] accept low stalls the port, no word is shifted
// [R8] accept sampled on port clock edges; high with request shifts data
// [R9] accept is resynchronised, no setup to the port clock assumed
// [R10] first word follows accept within one and a half port periods
// [R11] with accept held high, data starts one port clock after request
// [R12] i flag high with I word on bus, and for each packed word
// [R13] gain flag high exactly while the gain word is on the bus
// [R14] channel tag carries the channel number of the word shifted out
// [R15] words are twos complement, 16-bit interleaved, 8-bit halves packed
// [R16] interleaved order is I, then Q, then gain when appended
// [R17] packed mode puts I in the upper byte and Q in the lower byte
// [R18] pending channels are served from channel zero down to channel five
// [R19] six channel enables; only enabled channels are queued
// [R20] reset drops request and flags and discards a partly sent sample
`timescale 1ns/1ns
`include "pport_map.svh"
module pport_core (
	// clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// apb slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [11:0]                       paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// gain loop channel samples
	input  wire logic [`PP_CHANNELS-1:0]           sample_ready,
	input  wire pport_pkg::sample_t [`PP_CHANNELS-1:0] chan_sample,
	// port clock pin
	input  wire logic                              port_clk_in,
	output logic                                   port_clk_out,
	output logic                                   port_clk_oe,
	// port pins
	input  wire logic                              port_a_accept,
	output logic                                   port_a_request,
	output logic                                   port_a_i_flag,
	output logic                                   port_a_gain_flag,
	output logic      [2:0]                        port_a_channel_tag,
	output logic      [15:0]                       port_a_word_bus
);
	import pport_pkg::*;

	localparam core_state_t CORE_RESET = '{st: ST_IDLE, ctrl: ctrl_t'(`PP_CTRL_RESET),
		default: '0};

	core_state_t               s;
	core_state_t               next_s;
	logic                      clk_sync;
	logic                      accept;
	logic                      tick;
	logic                      setup;
	logic                      access;
	logic                      mapped;
	logic                      start;
	logic                      last_done;
	logic [2:0]                ch;
	logic [`PP_CHANNELS-1:0]   taken;
	logic [`PP_CHANNELS-1:0]   pend_after;
	logic [31:0]               ctrl_word;
	logic [31:0]               status_word;

	function automatic logic [2:0] first_set(input logic [`PP_CHANNELS-1:0] v);
		first_set = 3'h0;
		for (int k = `PP_CHANNELS - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = 3'(k);
			end
		end
	endfunction

	// pin-side levels cross into pclk before any logic looks at them
	bit_sync #(
		.W (2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({port_clk_in, port_a_accept}),
		.q       ({clk_sync, accept})
	);                                                                         // [R9]

	port_clock_gen u_clk (
		.pclk          (pclk),
		.presetn       (presetn),
		.clk_master    (s.ctrl.clk_master),
		.div_code      (s.ctrl.div_code),
		.port_clk_sync (clk_sync),
		.port_edge     (tick),
		.port_clk_out  (port_clk_out),
		.port_clk_oe   (port_clk_oe)
	);

	always_comb begin
		ctrl_word                                  = 32'h0000_0000;
		ctrl_word[`PP_CTRL_EN_LSB +: `PP_CHANNELS] = s.ctrl.enable;
		ctrl_word[`PP_CTRL_PACKED_BIT]             = s.ctrl.packed_fmt;
		ctrl_word[`PP_CTRL_GAIN_BIT]               = s.ctrl.append_gain;
		ctrl_word[`PP_CTRL_MASTER_BIT]             = s.ctrl.clk_master;
		ctrl_word[`PP_CTRL_DIV_LSB +: 2]           = s.ctrl.div_code;
		status_word                                = 32'h0000_0000;
		status_word[`PP_ST_PEND_LSB +: `PP_CHANNELS] = s.pending;
		status_word[`PP_ST_REQ_BIT]                = s.pout.request;
		status_word[`PP_ST_STALL_BIT]              = s.pout.request & ~accept;
		status_word[`PP_ST_TAG_LSB +: 3]           = s.pout.tag;
	end

	always_comb begin
		next_s    = s;
		setup     = psel & ~penable;
		access    = psel & penable;
		mapped    = (paddr == `PP_CTRL_OFS) || (paddr == `PP_STATUS_OFS);
		start     = 1'b0;
		last_done = 1'b0;
		ch        = first_set(s.pending);                                      // [R18]
		taken     = '0;

		// read data is latched in the setup cycle so prdata comes from a flop
		if (setup) begin
			if (paddr == `PP_CTRL_OFS) begin
				next_s.prdata = ctrl_word;
			end else if (paddr == `PP_STATUS_OFS) begin
				next_s.prdata = status_word;
			end else begin
				next_s.prdata = 32'h0000_0000;
			end
		end
		if (access && pwrite && (paddr == `PP_CTRL_OFS)) begin
			next_s.ctrl.enable      = pwdata[`PP_CTRL_EN_LSB +: `PP_CHANNELS];  // [R19]
			next_s.ctrl.packed_fmt  = pwdata[`PP_CTRL_PACKED_BIT];
			next_s.ctrl.append_gain = pwdata[`PP_CTRL_GAIN_BIT];
			next_s.ctrl.clk_master  = pwdata[`PP_CTRL_MASTER_BIT];              // [R1]
			next_s.ctrl.div_code    = pwdata[`PP_CTRL_DIV_LSB +: 2];            // [R2]
		end

		// a new sample overwrites one still waiting on the same channel
		for (int c = 0; c < `PP_CHANNELS; c++) begin
			if (sample_ready[c] && s.ctrl.enable[c]) begin
				next_s.hold[c] = chan_sample[c];
			end
		end

		// format changes take effect word by word; change them while idle
		if (tick) begin                                                        // [R5]
			case (s.st)
				ST_IDLE: begin
					if (s.pout.request && accept && (|s.pending)) begin  // [R8] [R10] [R11]
						start = 1'b1;
					end
				end
				ST_FIRST: begin
					if (accept) begin                                          // [R7]
						if (!s.ctrl.packed_fmt) begin
							next_s.st             = ST_SECOND;                 // [R16]
							next_s.pout.word      = s.cur.q_word;
							next_s.pout.i_flag    = 1'b0;                      // [R12]
						end else if (s.ctrl.append_gain) begin
							next_s.st             = ST_GAIN;
							next_s.pout.word      = s.cur.gain_word;
							next_s.pout.i_flag    = 1'b0;
							next_s.pout.gain_flag = 1'b1;                      // [R13]
						end else begin
							last_done = 1'b1;
						end
					end
				end
				ST_SECOND: begin
					if (accept) begin                                          // [R7]
						if (s.ctrl.append_gain) begin
							next_s.st             = ST_GAIN;                   // [R16]
							next_s.pout.word      = s.cur.gain_word;
							next_s.pout.gain_flag = 1'b1;                      // [R13]
						end else begin
							last_done = 1'b1;
						end
					end
				end
				ST_GAIN: begin
					if (accept) begin                                          // [R7]
						last_done = 1'b1;
					end
				end
				default: begin
					next_s.st = ST_IDLE;
				end
			endcase

			if (last_done) begin
				if (|s.pending) begin
					start = 1'b1;
				end else begin
					next_s.st             = ST_IDLE;
					next_s.pout.i_flag    = 1'b0;
					next_s.pout.gain_flag = 1'b0;
				end
			end

			if (start) begin
				taken[ch]             = 1'b1;
				next_s.cur            = s.hold[ch];
				next_s.st             = ST_FIRST;
				next_s.pout.tag       = ch;                                    // [R14]
				next_s.pout.i_flag    = 1'b1;                                  // [R12]
				next_s.pout.gain_flag = 1'b0;
				if (s.ctrl.packed_fmt) begin
					// twos complement: the top byte is the 8-bit component
					next_s.pout.word = {s.hold[ch].i_word[15:8],
						s.hold[ch].q_word[15:8]};                             // [R15] [R17]
				end else begin
					next_s.pout.word = s.hold[ch].i_word;                      // [R15] [R16]
				end
			end
		end

		pend_after = s.pending & ~taken;
		if (tick) begin
			next_s.pout.request = (next_s.st != ST_IDLE) || (|pend_after);    // [R6]
		end
		// an arriving sample wins over the take of the same channel
		next_s.pending = pend_after | (sample_ready & s.ctrl.enable);         // [R19]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= CORE_RESET;                                                   // [R20]
		end else begin
			s <= next_s;
		end
	end

	assign prdata             = s.prdata;
	assign pready             = 1'b1;
	assign pslverr            = psel & penable & ~mapped;
	assign port_a_request     = s.pout.request;
	assign port_a_i_flag      = s.pout.i_flag;
	assign port_a_gain_flag   = s.pout.gain_flag;
	assign port_a_channel_tag = s.pout.tag;
	assign port_a_word_bus    = s.pout.word;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_idle_ready;
		tick && accept && port_a_request && (s.st == ST_IDLE);
	endsequence

	sequence seq_i_taken;
		tick && accept && (s.st == ST_FIRST) && !s.ctrl.packed_fmt;
	endsequence

	property p_pin_driven;
		s.ctrl.clk_master |=> port_clk_oe;
	endproperty
	a_pin_driven: assert property (p_pin_driven)                           // [R1]
		else $error("port clock pin not driven in master mode");

	property p_pin_released;
		!s.ctrl.clk_master |=> !port_clk_oe;
	endproperty
	a_pin_released: assert property (p_pin_released)                       // [R4]
		else $error("port clock pin driven in slave mode");

	property p_only_on_edge;
		!tick |=> $stable(port_a_word_bus) && $stable(port_a_request)
			&& $stable(port_a_i_flag) && $stable(port_a_gain_flag)
			&& $stable(port_a_channel_tag);
	endproperty
	a_only_on_edge: assert property (p_only_on_edge)                       // [R5]
		else $error("port output changed off a port clock edge");

	property p_request_held;
		(s.st != ST_IDLE) |-> port_a_request;
	endproperty
	a_request_held: assert property (p_request_held)                       // [R6]
		else $error("request low while a sample is being sent");

	property p_stall;
		(tick && !accept && (s.st != ST_IDLE)) |=> $stable(s.st)
			&& $stable(port_a_word_bus);
	endproperty
	a_stall: assert property (p_stall)                                     // [R7]
		else $error("word shifted while accept low");

	property p_start;
		seq_idle_ready |=> (s.st == ST_FIRST) && port_a_i_flag && !port_a_gain_flag;
	endproperty
	a_start: assert property (p_start)                                     // [R8]
		else $error("accepted request did not put the first word out");

	property p_no_early_data;
		(tick && (s.st == ST_IDLE) && !port_a_request) |=> (s.st == ST_IDLE);
	endproperty
	a_no_early_data: assert property (p_no_early_data)                     // [R11]
		else $error("data started with request instead of one edge later");

	property p_i_flag;
		port_a_i_flag == (s.st == ST_FIRST);
	endproperty
	a_i_flag: assert property (p_i_flag)                                   // [R12]
		else $error("i flag does not match the I word");

	property p_gain_flag;
		port_a_gain_flag == (s.st == ST_GAIN);
	endproperty
	a_gain_flag: assert property (p_gain_flag)                             // [R13]
		else $error("gain flag does not match the gain word");

	property p_q_follows;
		seq_i_taken |=> (s.st == ST_SECOND) && (port_a_word_bus == s.cur.q_word)
			&& !port_a_i_flag;
	endproperty
	a_q_follows: assert property (p_q_follows)                             // [R16]
		else $error("Q word did not follow the I word");

	property p_packed_word;
		(seq_idle_ready ##0 s.ctrl.packed_fmt) |=> port_a_word_bus
			== {s.cur.i_word[15:8], s.cur.q_word[15:8]};
	endproperty
	a_packed_word: assert property (p_packed_word)                         // [R17]
		else $error("packed word has wrong byte placement");

	property p_priority;
		(seq_idle_ready ##0 s.pending[0]) |=> (port_a_channel_tag == 3'h0);
	endproperty
	a_priority: assert property (p_priority)                               // [R18] [R14]
		else $error("channel zero not served first");

	property p_disabled_not_queued;
		(!s.pending[0] && !(sample_ready[0] && s.ctrl.enable[0])) |=> !s.pending[0];
	endproperty
	a_disabled_not_queued: assert property (p_disabled_not_queued)         // [R19]
		else $error("disabled channel was queued");
endmodule

// ===== test/pport_partner.sv
// Purpose: receiving logic at the far side of the sample port
// Assumes: bench resolves the clock pin; bench sets run_clk and hold_off
// Notes:   logs each bus state standing while request is high
`timescale 1ns/1ns
module pport_partner (
	// bench control
	input  wire logic        run_clk,
	input  wire logic        hold_off,
	// port pins
	input  wire logic        clk_pin,
	input  wire logic        request,
	input  wire logic        i_flag,
	input  wire logic        gain_flag,
	input  wire logic [2:0]  tag,
	input  wire logic [15:0] word,
	output logic             accept,
	output logic             clk_drive
);
	logic [20:0] log_q[$];

	// 400 ns period, odd start offset so its edges keep a fixed 17 ns offset and never meet a pclk edge
	initial begin
		clk_drive = 1'b0;
		#17;
		forever begin
			#200;
			clk_drive = run_clk ? !clk_drive : 1'b0;
		end
	end

	// accept moves off any clock edge; the port must resynchronise it
	always @(hold_off) begin
		accept <= #13 !hold_off;
	end

	// bus stands from tick to tick, so the falling pin edge is a safe sample point
	always @(negedge clk_pin) begin
		if (request === 1'b1)
			log_q.push_back({i_flag, gain_flag, tag, word});
	end
endmodule

// ===== test/test_pport_core.sv
// Purpose: self-checking bench for the sample output port
// Assumes: 20 MHz pclk; far side modelled by pport_partner
// Notes:   port words are judged from the partner log
`timescale 1ns/1ns
`include "pport_map.svh"
module test_pport_core;
	import pport_pkg::*;

	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata;
	logic [5:0]        sample_ready;
	sample_t [5:0]     chan_sample;
	logic              port_clk_out, port_clk_oe, accept, request, i_flag, gain_flag;
	logic [2:0]        tag;
	logic [15:0]       word;
	logic              run_clk, hold_off, part_clk, packed_on, gain_on;
	logic [20:0]       exp_q[$];
	int                bad_count, compares;
	wire               port_pin = port_clk_oe ? port_clk_out : part_clk;

	initial pclk = 1'b0;
	always #25 pclk = !pclk;

	pport_core pport_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_ready(sample_ready), .chan_sample(chan_sample),
		.port_clk_in(port_pin), .port_clk_out(port_clk_out), .port_clk_oe(port_clk_oe),
		.port_a_accept(accept), .port_a_request(request), .port_a_i_flag(i_flag),
		.port_a_gain_flag(gain_flag), .port_a_channel_tag(tag), .port_a_word_bus(word));

	pport_partner pport_partner_inst (.run_clk(run_clk), .hold_off(hold_off),
		.clk_pin(port_pin), .request(request), .i_flag(i_flag), .gain_flag(gain_flag),
		.tag(tag), .word(word), .accept(accept), .clk_drive(part_clk));

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] cfg(input logic [5:0] en, input logic pk, input logic g,
		input logic m, input logic [1:0] d);
		cfg = 32'(en) << `PP_CTRL_EN_LSB;
		cfg[`PP_CTRL_PACKED_BIT] = pk;
		cfg[`PP_CTRL_GAIN_BIT] = g;
		cfg[`PP_CTRL_MASTER_BIT] = m;
		cfg[`PP_CTRL_DIV_LSB +: 2] = d;
	endfunction

	task automatic setup(input logic [5:0] en, input logic pk, input logic g,
		input logic m, input logic [1:0] d);
		logic [31:0] r;
		logic        e;
		packed_on = pk;
		gain_on = g;
		apb(1'b1, `PP_CTRL_OFS, cfg(en, pk, g, m, d), r, e);
	endtask

	// negative i words and gain words exercise the sign bit on the bus
	function automatic sample_t smp(input int c, input int k);
		smp.i_word = 16'h9000 + 16'(c * 256 + k);
		smp.q_word = 16'h6000 + 16'(c * 256 + k);
		smp.gain_word = 16'hc000 + 16'(c * 16 + k);
	endfunction

	task automatic send(input logic [5:0] mask, input int k);
		@(posedge pclk);
		for (int c = 0; c < 6; c++)
			chan_sample[c] <= smp(c, k);
		sample_ready <= mask;
		@(posedge pclk);
		sample_ready <= 6'h00;
	endtask

	task automatic expect_sample(input int c, input int k);
		sample_t s;
		s = smp(c, k);
		if (packed_on)
			exp_q.push_back({2'b10, 3'(c), s.i_word[15:8], s.q_word[15:8]});
		else begin
			exp_q.push_back({2'b10, 3'(c), s.i_word});
			exp_q.push_back({2'b00, 3'(c), s.q_word});
		end
		if (gain_on)
			exp_q.push_back({2'b01, 3'(c), s.gain_word});
	endtask

	task automatic wait_req(input logic v);
		for (int n = 0; n < 400 && request !== v; n++)
			@(negedge pclk);
		check("request", v, request);
	endtask

	// lead below zero: stale states before the first word are not counted
	task automatic check_log(input int lead);
		int base;
		wait_req(1'b1);
		wait_req(1'b0);
		base = pport_partner_inst.log_q.size() - exp_q.size();
		if (lead >= 0)
			check("log length", lead, base);
		for (int n = 0; n < exp_q.size(); n++)
			check("port word", exp_q[n], pport_partner_inst.log_q[base + n]);
		exp_q.delete();
		pport_partner_inst.log_q.delete();
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		check("clock pin enable", 1'b0, port_clk_oe);
		check("idle outputs", 3'b000, {request, i_flag, gain_flag});
		apb(1'b0, `PP_CTRL_OFS, 32'h0, r, e);
		check("ctrl reset", 32'h0, r);
		apb(1'b1, `PP_CTRL_OFS, cfg(6'h3f, 1'b1, 1'b1, 1'b1, 2'h3), r, e);
		apb(1'b0, `PP_CTRL_OFS, 32'h0, r, e);
		check("ctrl readback", cfg(6'h3f, 1'b1, 1'b1, 1'b1, 2'h3), r);
		apb(1'b1, `PP_STATUS_OFS, 32'hffffffff, r, e);
		apb(1'b0, `PP_STATUS_OFS, 32'h0, r, e);
		check("status read only", 32'h0, r);
		apb(1'b0, 12'h010, 32'h0, r, e);
		check("unmapped error", 1'b1, e);
		check("unmapped read", 32'h0, r);
		setup(6'h00, 1'b0, 1'b0, 1'b0, 2'h0);
	endtask

	task automatic t_formats();
		for (int f = 0; f < 4; f++) begin
			setup(6'h04, f[0], f[1], 1'b0, 2'h0);
			send(6'h04, f);
			expect_sample(2, f);
			check_log(1);
		end
	endtask

	task automatic t_priority();
		setup(6'h29, 1'b0, 1'b1, 1'b0, 2'h0);
		send(6'h2b, 7);
		expect_sample(0, 7);
		expect_sample(3, 7);
		expect_sample(5, 7);
		check_log(1);
	endtask

	task automatic t_stall();
		int          n;
		logic [31:0] r;
		logic        e;
		setup(6'h10, 1'b1, 1'b0, 1'b0, 2'h0);
		hold_off <= 1'b1;
		send(6'h10, 3);
		expect_sample(4, 3);
		wait_req(1'b1);
		repeat (40) @(negedge pclk);
		n = 0;
		foreach (pport_partner_inst.log_q[j])
			n += int'(pport_partner_inst.log_q[j][20:19] != 2'b00);
		check("words while stalled", 0, n);
		check("request held", 1'b1, request);
		apb(1'b0, `PP_STATUS_OFS, 32'h0, r, e);
		check("stall status", 10'h310, r[9:0]);
		@(posedge pclk);
		hold_off <= 1'b0;
		for (n = 0; n < 30 && i_flag !== 1'b1; n++)
			@(negedge pclk);
		// accept lands 13 ns after this edge; 1.5 port periods is 12 pclk
		check("accept latency", 1'b1, n <= 12);
		check_log(-1);
	endtask

	task automatic t_master();
		int   n;
		logic p;
		run_clk <= 1'b0;
		for (int d = 0; d < 4; d++) begin
			setup(6'h01, 1'b0, 1'b0, 1'b1, 2'(d));
			repeat (3) @(negedge pclk);
			check("clock pin enable", 1'b1, port_clk_oe);
			p = port_pin;
			n = 0;
			repeat (16) begin
				@(negedge pclk);
				n += int'(port_pin && !p);
				p = port_pin;
			end
			// divisor one cannot toggle, so the pin is held high instead
			check("clock pin rises", d == 0 ? 0 : 16 >> d, n);
			check("clock pin level", 1'b1, port_pin | (d != 0));
			send(6'h01, 10 + d);
			expect_sample(0, 10 + d);
			if (d == 0) begin
				wait_req(1'b1);
				wait_req(1'b0);
			end else
				check_log(1);
			pport_partner_inst.log_q.delete();
			exp_q.delete();
		end
		setup(6'h00, 1'b0, 1'b0, 1'b0, 2'h0);
		run_clk <= 1'b1;
		repeat (3) @(negedge pclk);
		check("clock pin released", 1'b0, port_clk_oe);
	endtask

	task automatic t_midreset();
		logic [31:0] r;
		logic        e;
		setup(6'h02, 1'b0, 1'b1, 1'b0, 2'h0);
		send(6'h02, 5);
		for (int n = 0; n < 60 && i_flag !== 1'b1; n++)
			@(negedge pclk);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		check("outputs in reset", 4'h0, {request, i_flag, gain_flag, port_clk_oe});
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		setup(6'h02, 1'b0, 1'b1, 1'b0, 2'h0);
		repeat (40) @(negedge pclk);
		check("request after reset", 1'b0, request);
		apb(1'b0, `PP_STATUS_OFS, 32'h0, r, e);
		check("pending after reset", 6'h00, r[`PP_ST_PEND_LSB +: 6]);
	endtask

	initial begin
		watchdog: begin
			repeat (20000) @(posedge pclk);
			bad_count++;
			results();
		end
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sample_ready = 6'h00;
		chan_sample = '0;
		hold_off = 1'b1;
		run_clk = 1'b0;
		bad_count = 0;
		compares = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		hold_off <= 1'b0;
		run_clk <= 1'b1;
		repeat (2) @(negedge pclk);
		t_reset();
		t_formats();
		t_priority();
		t_stall();
		t_master();
		t_midreset();
		results();
	end
endmodule
